// ### core/nsgs_pkg.sv
// shared constants and types for the network status word and group filter
package nsgs_pkg;

	// ==========================================================
	// status word geometry
	localparam int NSGS_WORD_W = 16; // bits in the remote status word
	localparam int NSGS_SEL_W = 7; // width of one bit-source selector
	localparam int NSGS_NUM_SRC = 128; // selector space

	// ==========================================================
	// source codes for a status bit
	localparam logic [6:0] SRC_UNUSED = 7'h00;
	localparam logic [6:0] SRC_FWD = 7'h01;
	localparam logic [6:0] SRC_RVS = 7'h02;
	localparam logic [6:0] SRC_HOME = 7'h03;
	localparam logic [6:0] SRC_START = 7'h04;
	localparam logic [6:0] SRC_SSTART = 7'h05;
	localparam logic [6:0] SRC_JOGP = 7'h06;
	localparam logic [6:0] SRC_JOGM = 7'h07;
	localparam logic [6:0] SRC_FREE = 7'h08;
	localparam logic [6:0] SRC_AWO = 7'h09;
	localparam logic [6:0] SRC_STOP = 7'h0A;
	localparam logic [6:0] SRC_MS0 = 7'h10; // 0x10..0x15 direct-select echoes
	localparam logic [6:0] SRC_M0 = 7'h18; // 0x18..0x1D data-number echoes
	localparam logic [6:0] SRC_LSP = 7'h20;
	localparam logic [6:0] SRC_LSM = 7'h21;
	localparam logic [6:0] SRC_HOMES = 7'h22;
	localparam logic [6:0] SRC_SLIT = 7'h23;
	localparam logic [6:0] SRC_R0 = 7'h30; // 0x30..0x3F general-purpose flags
	localparam logic [6:0] SRC_ALARM = 7'h40;
	localparam logic [6:0] SRC_WARN = 7'h41;
	localparam logic [6:0] SRC_READY = 7'h42;
	localparam logic [6:0] SRC_MOVE = 7'h43;
	localparam logic [6:0] SRC_HOMEP = 7'h44;
	localparam logic [6:0] SRC_TICK = 7'h45;
	localparam logic [6:0] SRC_AREA1 = 7'h46; // 0x46..0x48 zone flags
	localparam logic [6:0] SRC_SBSY = 7'h49;
	localparam logic [6:0] SRC_SUPPLY = 7'h4A;
	localparam logic [6:0] SRC_DEV = 7'h4B;
	localparam logic [6:0] SRC_HEAT = 7'h4C;
	localparam logic [6:0] SRC_INDEX = 7'h4D;
	localparam logic [6:0] SRC_BRAKE = 7'h4E;

	// ==========================================================
	// group setting command codes and values
	localparam logic [15:0] CMD_GROUP_RD = 16'h0018; // read code 24
	localparam logic [15:0] CMD_GROUP_WR = 16'h1018; // write code 4120
	localparam logic signed [31:0] GROUP_NONE = -32'sd1; // individual
	localparam logic signed [31:0] GROUP_MAX = 32'sh0000000F; // highest group address
	localparam logic [3:0] ADDR_ZERO = 4'h0;

	// ==========================================================
	// angle tick: one pulse per 7.2 degrees
	localparam int TICK_ANGLE_CENTIDEG = 720; // 7.2 degrees in hundredths
	localparam int STEP_ANGLE_CENTIDEG = 72; // full step of a 5-phase motor
	localparam int TICK_STEPS = TICK_ANGLE_CENTIDEG / STEP_ANGLE_CENTIDEG;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic fwd;
		logic rvs;
		logic home;
		logic start;
		logic sstart;
		logic jog_p;
		logic jog_m;
		logic free;
		logic awo;
		logic stop;
		logic [5:0] ms;
		logic [5:0] m;
	} nsgs_cmd_t; // remote input commands in force

	typedef struct packed {
		logic lsp;
		logic lsm;
		logic homes;
		logic slit;
	} nsgs_sensor_t; // sensor input levels

	typedef struct packed {
		logic alarm;
		logic warning;
		logic ready;
		logic moving;
		logic at_home;
		logic [2:0] zone;
		logic busy;
		logic supply_on;
		logic dev_err;
		logic overheat;
		logic enc_index;
		logic brake_rel;
	} nsgs_drv_t; // driver state

	typedef logic [6:0] nsgs_sel_t;

endpackage : nsgs_pkg

// ### core/nsgs_tick.sv
// angle tick generator: one pulse per 7.2 degrees of shaft travel
`timescale 1ns/100ps
module nsgs_tick #(
	parameter int STEPS = nsgs_pkg::TICK_STEPS
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// step events
	input wire logic step_en,
	input wire logic step_dir,
	// tick level
	output logic tick_q
);
	import nsgs_pkg::*;

	localparam logic [7:0] LAST = 8'(STEPS - 1); // top of the step count

	logic [7:0] cnt_q; // position within the 7.2 degree window

	// ==========================================================
	// step counter, wraps in both directions so the tick tracks angle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= 8'h00;
		end else if (step_en) begin
			if (step_dir) begin
				cnt_q <= (cnt_q == LAST) ? 8'h00 : cnt_q + 8'h01;
			end else begin
				cnt_q <= (cnt_q == 8'h00) ? LAST : cnt_q - 8'h01;
			end
		end
	end

	// tick on while at window origin, so it repeats every 7.2 degrees
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= (cnt_q == 8'h00);
		end
	end

endmodule : nsgs_tick

// ### core/nsgs_selmem.sv
// sixteen-entry memory of bit-source selectors, registered read
`timescale 1ns/100ps
module nsgs_selmem #(
	parameter int DEPTH = nsgs_pkg::NSGS_WORD_W
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// write port
	input wire logic wr_en,
	input wire logic [3:0] wr_idx,
	input wire nsgs_pkg::nsgs_sel_t wr_sel,
	// read port, all entries at once
	output nsgs_pkg::nsgs_sel_t rd_sel [DEPTH]
);
	import nsgs_pkg::*;

	nsgs_sel_t mem_q [DEPTH]; // stored selectors

	// ==========================================================
	// selector store; reset gives the factory bit layout
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mem_q[0] <= SRC_M0;
			mem_q[1] <= SRC_M0 + 7'h01;
			mem_q[2] <= SRC_M0 + 7'h02;
			mem_q[3] <= SRC_START;
			mem_q[4] <= SRC_HOMEP;
			mem_q[5] <= SRC_READY;
			mem_q[6] <= SRC_WARN;
			mem_q[7] <= SRC_ALARM;
			mem_q[8] <= SRC_SBSY;
			mem_q[9] <= SRC_AREA1;
			mem_q[10] <= SRC_AREA1 + 7'h01;
			mem_q[11] <= SRC_AREA1 + 7'h02;
			mem_q[12] <= SRC_TICK;
			mem_q[13] <= SRC_MOVE;
			mem_q[14] <= SRC_UNUSED;
			mem_q[15] <= SRC_DEV;
		end else if (wr_en) begin
			mem_q[wr_idx] <= wr_sel;
		end
	end

	// read data come out of a register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				rd_sel[i] <= SRC_UNUSED;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				rd_sel[i] <= mem_q[i];
			end
		end
	end

endmodule : nsgs_selmem

// ### core/nsgs_top.sv
// remote status word builder and group address filter
// Functional notes
// - each status bit picks its source by parameter
// - command echoes follow their input commands
// - sensor echoes follow limit, home, slit inputs
// - general-purpose flags selectable as status bits
// - alarm bit is one while alarm present
// - warning bit is one while warning present
// - ready bit is one when operation accepted
// - motion bit is one while motor operates
// - home bit is one at home position
// - tick pulses once per 7.2 degrees
// - zone bits one while inside each area
// - busy bit one during internal processing
// - supply bit one while main power on
// - deviation bit one during deviation error
// - overheat bit one during overheat warning
// - index bit one when encoder index seen
// - brake bit one when brake released
// - children act on inputs sent to group address
// - group address is the parent's own address
// - group read 24, write 4120, range -1..15
// - group delivery only for remote input bits
// - group setting volatile, skipped by batch save
// - inputs to child address never move group
`timescale 1ns/100ps
module nsgs_top #(
	parameter int WORD_W = nsgs_pkg::NSGS_WORD_W
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// own station address
	input wire logic [3:0] station_addr,
	// remote input frame from the network converter
	input wire logic rin_valid,
	input wire logic [3:0] rin_addr,
	input wire logic [15:0] rin_word,
	// command frame from the network converter
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_addr,
	input wire logic [15:0] cmd_code,
	input wire logic signed [31:0] cmd_data,
	// bit-source parameter writes
	input wire logic sel_wr_en,
	input wire logic [3:0] sel_wr_idx,
	input wire nsgs_pkg::nsgs_sel_t sel_wr_val,
	// remote input commands in force, general flags, sensors, driver state
	input wire nsgs_pkg::nsgs_cmd_t cmd_state,
	input wire logic [15:0] gp_flags,
	input wire nsgs_pkg::nsgs_sensor_t sensors,
	input wire nsgs_pkg::nsgs_drv_t drv,
	// step events for the angle tick
	input wire logic step_en,
	input wire logic step_dir,
	// batch non-volatile save request
	input wire logic nv_save,
	// remote status word back to the converter
	output logic [15:0] remote_status_bits,
	// accepted remote input word and its strobe
	output logic rin_take_q,
	output logic [15:0] rin_word_q,
	// command response
	output logic cmd_done_q,
	output logic cmd_err_q,
	output logic signed [31:0] cmd_rdata_q,
	// snapshot for non-volatile save, group excluded
	output logic nv_save_q,
	output logic [15:0] nv_sel_img_q
);
	import nsgs_pkg::*;

	// ==========================================================
	// declarations
	nsgs_sel_t sel [WORD_W]; // registered selectors
	logic tick; // angle tick level
	logic [NSGS_NUM_SRC-1:0] src_vec; // every selectable source
	logic [15:0] status_d; // next status word
	logic signed [31:0] group_q; // group setting, volatile
	logic own_hit; // frame addressed to this station
	logic grp_hit; // frame addressed to our parent
	logic own_cmd; // command frame for this station

	typedef enum logic [2:0] {
		NSGS_IDLE = 3'b001,
		NSGS_EXEC = 3'b010,
		NSGS_RESP = 3'b100
	} nsgs_state_t;
	nsgs_state_t state_q; // command handling state
	logic [15:0] code_q; // latched command code
	logic signed [31:0] data_q; // latched command data

	// ==========================================================
	// leaf blocks
	nsgs_selmem #(
		.DEPTH(WORD_W)
	) u_selmem (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(sel_wr_en),
		.wr_idx(sel_wr_idx),
		.wr_sel(sel_wr_val),
		.rd_sel(sel)
	);

	nsgs_tick #(
		.STEPS(TICK_STEPS)
	) u_tick (
		.clk_sys(clk_sys),
		.rst(rst),
		.step_en(step_en),
		.step_dir(step_dir),
		.tick_q(tick)
	);

	// ==========================================================
	// functions
	// true when the group setting names a parent address
	function automatic logic group_on(input logic signed [31:0] g);
		group_on = (g != GROUP_NONE);
	endfunction : group_on

	// value range check for a group write
	function automatic logic group_ok(input logic signed [31:0] v);
		group_ok = (v >= GROUP_NONE) && (v <= GROUP_MAX);
	endfunction : group_ok

	// ==========================================================
	// source vector; index is the selector code
	always_comb begin
		src_vec = '0;
		src_vec[SRC_UNUSED] = 1'b0;
		src_vec[SRC_FWD] = cmd_state.fwd;
		src_vec[SRC_RVS] = cmd_state.rvs;
		src_vec[SRC_HOME] = cmd_state.home;
		src_vec[SRC_START] = cmd_state.start;
		src_vec[SRC_SSTART] = cmd_state.sstart;
		src_vec[SRC_JOGP] = cmd_state.jog_p;
		src_vec[SRC_JOGM] = cmd_state.jog_m;
		src_vec[SRC_FREE] = cmd_state.free;
		src_vec[SRC_AWO] = cmd_state.awo;
		src_vec[SRC_STOP] = cmd_state.stop;
		for (int i = 0; i < 6; i++) begin
			src_vec[SRC_MS0 + 7'(i)] = cmd_state.ms[i];
			src_vec[SRC_M0 + 7'(i)] = cmd_state.m[i];
		end
		src_vec[SRC_LSP] = sensors.lsp;
		src_vec[SRC_LSM] = sensors.lsm;
		src_vec[SRC_HOMES] = sensors.homes;
		src_vec[SRC_SLIT] = sensors.slit;
		for (int i = 0; i < 16; i++) begin
			src_vec[SRC_R0 + 7'(i)] = gp_flags[i];
		end
		src_vec[SRC_ALARM] = drv.alarm;
		src_vec[SRC_WARN] = drv.warning;
		src_vec[SRC_READY] = drv.ready;
		src_vec[SRC_MOVE] = drv.moving;
		src_vec[SRC_HOMEP] = drv.at_home;
		src_vec[SRC_TICK] = tick;
		for (int i = 0; i < 3; i++) begin
			src_vec[SRC_AREA1 + 7'(i)] = drv.zone[i];
		end
		src_vec[SRC_SBSY] = drv.busy;
		src_vec[SRC_SUPPLY] = drv.supply_on;
		src_vec[SRC_DEV] = drv.dev_err;
		src_vec[SRC_HEAT] = drv.overheat;
		src_vec[SRC_INDEX] = drv.enc_index;
		src_vec[SRC_BRAKE] = drv.brake_rel;
	end

	// per-bit multiplexer; unmapped codes fall on zero entries
	always_comb begin
		for (int b = 0; b < 16; b++) begin
			status_d[b] = src_vec[sel[b]];
		end
	end

	// ==========================================================
	// status word register, one cycle behind its sources
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			remote_status_bits <= 16'h0000;
		end else begin
			remote_status_bits <= status_d;
		end
	end

	// ==========================================================
	// address match for remote input frames
	// the parent needs nothing: its own address is the group address
	assign own_hit = (rin_addr == station_addr);
	assign grp_hit = group_on(group_q) && (rin_addr == group_q[3:0]);
	// a frame to a child address reaches only that child; no forwarding
	// exists here, so the group never moves from it
	assign own_cmd = cmd_valid && (cmd_addr == station_addr);

	// remote input acceptance
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rin_take_q <= 1'b0;
			rin_word_q <= 16'h0000;
		end else begin
			rin_take_q <= rin_valid && (own_hit || grp_hit);
			if (rin_valid && (own_hit || grp_hit)) begin
				rin_word_q <= rin_word;
			end
		end
	end

	// ==========================================================
	// command handling; only frames to the own address execute,
	// so group-addressed reads and writes are ignored
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= NSGS_IDLE;
			code_q <= 16'h0000;
			data_q <= 32'sh00000000;
		end else begin
			case (state_q)
				NSGS_IDLE: begin
					if (own_cmd) begin
						code_q <= cmd_code;
						data_q <= cmd_data;
						state_q <= NSGS_EXEC;
					end
				end
				NSGS_EXEC: begin
					state_q <= NSGS_RESP;
				end
				NSGS_RESP: begin
					state_q <= NSGS_IDLE;
				end
				default: begin
					state_q <= NSGS_IDLE;
				end
			endcase
		end
	end

	// group setting; volatile, returns to individual on reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			group_q <= GROUP_NONE;
		end else if (state_q == NSGS_EXEC && code_q == CMD_GROUP_WR && group_ok(data_q)) begin
			group_q <= data_q;
		end
	end

	// response for one cycle after execution
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmd_done_q <= 1'b0;
			cmd_err_q <= 1'b0;
			cmd_rdata_q <= 32'sh00000000;
		end else if (state_q == NSGS_EXEC) begin
			cmd_done_q <= 1'b1;
			if (code_q == CMD_GROUP_RD) begin
				cmd_err_q <= 1'b0;
				cmd_rdata_q <= group_q;
			end else if (code_q == CMD_GROUP_WR) begin
				cmd_err_q <= !group_ok(data_q);
				cmd_rdata_q <= 32'sh00000000;
			end else begin
				// codes outside this block are answered as errors
				cmd_err_q <= 1'b1;
				cmd_rdata_q <= 32'sh00000000;
			end
		end else begin
			cmd_done_q <= 1'b0;
			cmd_err_q <= 1'b0;
		end
	end

	// ==========================================================
	// batch save snapshot: selectors are summarised, group never stored
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			nv_save_q <= 1'b0;
			nv_sel_img_q <= 16'h0000;
		end else begin
			nv_save_q <= nv_save;
			if (nv_save) begin
				for (int b = 0; b < 16; b++) begin
					nv_sel_img_q[b] <= (sel[b] != SRC_UNUSED);
				end
			end
		end
	end

endmodule : nsgs_top

// ### verif/nsgs_top_sva.sv
// checker for the status word, remote input filter and command timing
`timescale 1ns/100ps
module nsgs_top_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// watched inputs
	input wire logic [3:0] station_addr,
	input wire logic rin_valid,
	input wire logic [3:0] rin_addr,
	input wire logic [15:0] rin_word,
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_addr,
	input wire logic [15:0] cmd_code,
	input wire logic sel_wr_en,
	input wire nsgs_pkg::nsgs_drv_t drv,
	input wire logic nv_save,
	// watched outputs
	input wire logic [15:0] remote_status_bits,
	input wire logic rin_take_q,
	input wire logic [15:0] rin_word_q,
	input wire logic cmd_done_q,
	input wire logic cmd_err_q,
	input wire logic nv_save_q,
	input wire logic [15:0] nv_sel_img_q
);
	import nsgs_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// ==========
	// helpers
	logic [1:0] age_q; // edges since reset, saturates at 3
	logic dflt_q; // layout still as after reset
	logic [1:0] ph_q; // 0 idle, 1 exec, 2 done
	logic take; // command accepted this edge
	assign take = cmd_valid && (cmd_addr == station_addr) && (ph_q == 2'h0);
	// age and layout tracking, word is trusted only once the pipe is full
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			age_q <= 2'h0;
			dflt_q <= 1'b1;
		end else begin
			age_q <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
			dflt_q <= dflt_q && !sel_wr_en;
		end
	end
	// command phase, mirrors exec and response; a new take only when idle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ph_q <= 2'h0;
		end else begin
			ph_q <= take ? 2'h1 : ((ph_q == 2'h1) ? 2'h2 : 2'h0);
		end
	end
	// ==========
	// assertions
	a_rin_own_take: assert property (
		rin_valid && rin_addr == station_addr |=> rin_take_q && rin_word_q == $past(rin_word))
		else $error("own frame not taken");
	a_rin_no_frame: assert property (!rin_valid |=> !rin_take_q)
		else $error("take without frame");
	a_cmd_answer: assert property (take |-> ##2 cmd_done_q)
		else $error("command not answered");
	a_cmd_only_own: assert property (cmd_done_q |-> ph_q == 2'h2)
		else $error("done without own command");
	a_cmd_bad_code: assert property (
		take && cmd_code != CMD_GROUP_RD && cmd_code != CMD_GROUP_WR |-> ##2 cmd_err_q)
		else $error("unknown code not refused");
	a_alarm_bit: assert property (
		age_q == 2'h3 && dflt_q |-> remote_status_bits[7] == $past(drv.alarm))
		else $error("alarm bit wrong");
	a_warn_bit: assert property (
		age_q == 2'h3 && dflt_q |-> remote_status_bits[6] == $past(drv.warning))
		else $error("warning bit wrong");
	a_ready_bit: assert property (
		age_q == 2'h3 && dflt_q |-> remote_status_bits[5] == $past(drv.ready))
		else $error("ready bit wrong");
	a_zone_bits: assert property (
		age_q == 2'h3 && dflt_q |-> remote_status_bits[11:9] == $past(drv.zone))
		else $error("zone bits wrong");
	a_unused_zero: assert property (age_q == 2'h3 && dflt_q |-> !remote_status_bits[14])
		else $error("unused bit set");
	a_save_image: assert property (
		nv_save && dflt_q && age_q == 2'h3 |=> nv_save_q && nv_sel_img_q == 16'hBFFF)
		else $error("save image wrong");
	// main scenarios seen
	c_rin_taken: cover property (rin_take_q);
	c_cmd_err: cover property (cmd_done_q && cmd_err_q);
	c_save: cover property (nv_save_q);
endmodule : nsgs_top_sva
bind nsgs_top nsgs_top_sva u_sva (.clk_sys(clk_sys), .rst(rst), .station_addr(station_addr),
	.rin_valid(rin_valid), .rin_addr(rin_addr), .rin_word(rin_word), .cmd_valid(cmd_valid),
	.cmd_addr(cmd_addr), .cmd_code(cmd_code), .sel_wr_en(sel_wr_en), .drv(drv),
	.nv_save(nv_save), .remote_status_bits(remote_status_bits), .rin_take_q(rin_take_q),
	.rin_word_q(rin_word_q), .cmd_done_q(cmd_done_q), .cmd_err_q(cmd_err_q),
	.nv_save_q(nv_save_q), .nv_sel_img_q(nv_sel_img_q));

// ### verif/nsgs_conv.sv
// network converter model: remote input and command frames
`timescale 1ns/100ps
module nsgs_conv (
	// clock
	input wire logic clk_sys,
	// remote input frame
	output logic rin_valid,
	output logic [3:0] rin_addr,
	output logic [15:0] rin_word,
	// command frame
	output logic cmd_valid,
	output logic [3:0] cmd_addr,
	output logic [15:0] cmd_code,
	output logic signed [31:0] cmd_data,
	// response
	input wire logic cmd_done_q,
	input wire logic cmd_err_q,
	input wire logic signed [31:0] cmd_rdata_q
);
	// ==========
	// idle lines at time zero
	initial begin
		rin_valid = 1'b0;
		rin_addr = 4'hF;
		rin_word = 16'h0000;
		cmd_valid = 1'b0;
		cmd_addr = 4'hF;
		cmd_code = 16'h0000;
		cmd_data = 32'sh0;
	end
	// one-cycle frame; group frames carry the parent's own address
	task automatic rin_send(input logic [3:0] a, input logic [15:0] w);
		@(posedge clk_sys);
		rin_valid <= 1'b1;
		rin_addr <= a;
		rin_word <= w;
		@(posedge clk_sys);
		rin_valid <= 1'b0;
		// released lines show the inverse so a stale copy cannot pass
		rin_addr <= ~a;
		rin_word <= ~w;
	endtask : rin_send
	// command then a bounded wait for the answer
	task automatic cmd_send(input logic [3:0] a, input logic [15:0] c,
		input logic signed [31:0] d, output logic dn, output logic er,
		output logic signed [31:0] rd);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_addr <= a;
		cmd_code <= c;
		cmd_data <= d;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		cmd_code <= ~c;
		cmd_data <= ~d;
		dn = 1'b0;
		er = 1'b0;
		rd = 32'sh0;
		repeat (4) begin
			@(posedge clk_sys);
			if (cmd_done_q === 1'b1 && !dn) begin
				dn = 1'b1;
				er = cmd_err_q;
				rd = cmd_rdata_q;
			end
		end
	endtask : cmd_send
endmodule : nsgs_conv

// ### verif/nsgs_top_bench.sv
// self-checking bench for the status word builder and group filter
`timescale 1ns/100ps
module nsgs_top_bench;
	import nsgs_pkg::*;
	// ==========
	// signals
	localparam logic [3:0] ST = 4'h2; // own station
	localparam logic [3:0] PAR = 4'h0; // parent station
	localparam logic [55:0] PAT = 56'hA55A3CC3F00F96; // input pattern
	localparam logic [6:0] DFLT [16] = '{SRC_M0, 7'h19, 7'h1A, SRC_START, SRC_HOMEP, SRC_READY,
		SRC_WARN, SRC_ALARM, SRC_SBSY, SRC_AREA1, 7'h47, 7'h48, SRC_TICK, SRC_MOVE,
		SRC_UNUSED, SRC_DEV};
	logic clk_sys, rst, sel_wr_en, step_en, step_dir, nv_save;
	logic [3:0] sel_wr_idx, rin_addr, cmd_addr;
	nsgs_sel_t sel_wr_val;
	nsgs_cmd_t cmd_state;
	nsgs_sensor_t sensors;
	nsgs_drv_t drv;
	logic [15:0] gp_flags, remote_status_bits, rin_word_q, nv_sel_img_q, rin_word, cmd_code;
	logic rin_valid, rin_take_q, cmd_valid, cmd_done_q, cmd_err_q, nv_save_q, dn, er;
	logic signed [31:0] cmd_data, cmd_rdata_q, rd;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int tick_cnt = 0; // step position modulo ten
	// ==========
	// instances
	nsgs_top u_dut (.clk_sys(clk_sys), .rst(rst), .station_addr(ST), .rin_valid(rin_valid),
		.rin_addr(rin_addr), .rin_word(rin_word), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .sel_wr_en(sel_wr_en), .sel_wr_idx(sel_wr_idx),
		.sel_wr_val(sel_wr_val), .cmd_state(cmd_state), .gp_flags(gp_flags), .sensors(sensors),
		.drv(drv), .step_en(step_en), .step_dir(step_dir), .nv_save(nv_save),
		.remote_status_bits(remote_status_bits), .rin_take_q(rin_take_q),
		.rin_word_q(rin_word_q), .cmd_done_q(cmd_done_q), .cmd_err_q(cmd_err_q),
		.cmd_rdata_q(cmd_rdata_q), .nv_save_q(nv_save_q), .nv_sel_img_q(nv_sel_img_q));
	nsgs_conv u_conv (.clk_sys(clk_sys), .rin_valid(rin_valid), .rin_addr(rin_addr),
		.rin_word(rin_word), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_code(cmd_code),
		.cmd_data(cmd_data), .cmd_done_q(cmd_done_q), .cmd_err_q(cmd_err_q),
		.cmd_rdata_q(cmd_rdata_q));
	// ==========
	// clock and hang guard
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			num_errors = num_errors + 1;
			end_of_test();
		end
	end
	// ==========
	// helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("ERROR at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : check
	// source level for a selector code; tick and undefined codes read 0
	function automatic logic src(input logic [6:0] code);
		logic [127:0] v;
		v = '0;
		v[10:1] = {cmd_state.stop, cmd_state.awo, cmd_state.free, cmd_state.jog_m,
			cmd_state.jog_p, cmd_state.sstart, cmd_state.start, cmd_state.home,
			cmd_state.rvs, cmd_state.fwd};
		v[21:16] = cmd_state.ms;
		v[29:24] = cmd_state.m;
		v[35:32] = {sensors.slit, sensors.homes, sensors.lsm, sensors.lsp};
		v[63:48] = gp_flags;
		v[68:64] = {drv.at_home, drv.moving, drv.ready, drv.warning, drv.alarm};
		v[78:70] = {drv.brake_rel, drv.enc_index, drv.overheat, drv.dev_err, drv.supply_on,
			drv.busy, drv.zone};
		return v[code];
	endfunction : src
	task automatic apply(input logic [55:0] p);
		@(posedge clk_sys);
		{cmd_state, gp_flags, sensors, drv} <= p;
		repeat (4) @(posedge clk_sys);
	endtask : apply
	task automatic rin_chk(input logic [3:0] a, input logic [15:0] w, input logic exp);
		logic [15:0] prev;
		prev = rin_word_q;
		u_conv.rin_send(a, w);
		@(posedge clk_sys);
		check(rin_take_q, exp);
		check(rin_word_q, exp ? w : prev);
	endtask : rin_chk
	task automatic cmd_chk(input logic [3:0] a, input logic [15:0] c,
		input logic signed [31:0] d, input logic [1:0] exp);
		u_conv.cmd_send(a, c, d, dn, er, rd);
		check({dn, er}, exp);
	endtask : cmd_chk
	// ==========
	// scenarios
	task automatic t_default();
		for (int k = 0; k < 3; k++) begin
			apply(k == 0 ? PAT : (k == 1 ? ~PAT : '1));
			for (int b = 0; b < 16; b++) begin
				if (b != 12) check(remote_status_bits[b], src(DFLT[b]));
			end
		end
	endtask : t_default
	task automatic t_tick();
		check(remote_status_bits[12], 1'b1);
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_sys);
			step_en <= 1'b1;
			step_dir <= (i != 10);
			@(posedge clk_sys);
			step_en <= 1'b0;
			tick_cnt = (i != 10) ? (tick_cnt + 1) % 10 : (tick_cnt + 9) % 10;
			repeat (4) @(posedge clk_sys);
			check(remote_status_bits[12], tick_cnt == 0);
		end
	endtask : t_tick
	task automatic t_save();
		@(posedge clk_sys);
		nv_save <= 1'b1;
		@(posedge clk_sys);
		nv_save <= 1'b0;
		@(posedge clk_sys);
		check({nv_save_q, nv_sel_img_q}, {1'b1, 16'hBFFF});
	endtask : t_save
	task automatic t_group();
		cmd_chk(ST, CMD_GROUP_RD, 0, 2'b10);
		check(rd, GROUP_NONE);
		rin_chk(ST, 16'h1234, 1'b1);
		rin_chk(PAR, 16'h00F1, 1'b0);
		cmd_chk(ST, CMD_GROUP_WR, 16, 2'b11);
		cmd_chk(ST, CMD_GROUP_WR, -2, 2'b11);
		cmd_chk(ST, 16'h0019, 0, 2'b11);
		cmd_chk(ST, CMD_GROUP_WR, 0, 2'b10);
		rin_chk(PAR, 16'hBEEF, 1'b1);
		rin_chk(4'h5, 16'h0F0F, 1'b0);
		cmd_chk(PAR, CMD_GROUP_WR, 7, 2'b00);
		cmd_chk(ST, CMD_GROUP_RD, 0, 2'b10);
		check(rd, 0);
		cmd_chk(ST, CMD_GROUP_WR, 15, 2'b10);
		cmd_chk(ST, CMD_GROUP_RD, 0, 2'b10);
		check(rd, 15);
	endtask : t_group
	task automatic t_select();
		for (int k = 0; k < 2; k++) begin
			apply(k == 0 ? PAT : ~PAT);
			for (int c = 0; c < 128; c++) begin
				@(posedge clk_sys);
				sel_wr_en <= 1'b1;
				sel_wr_idx <= c[3:0];
				sel_wr_val <= c[6:0];
				@(posedge clk_sys);
				sel_wr_en <= 1'b0;
				repeat (4) @(posedge clk_sys);
				if (c != 69) check(remote_status_bits[c[3:0]], src(c[6:0]));
			end
		end
	endtask : t_select
	task automatic t_revert();
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		cmd_chk(ST, CMD_GROUP_RD, 0, 2'b10);
		check(rd, GROUP_NONE);
	endtask : t_revert
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test
	// ==========
	// main sequence
	initial begin
		rst = 1'b1;
		{sel_wr_en, step_en, step_dir, nv_save, sel_wr_idx, sel_wr_val} = '0;
		{cmd_state, gp_flags, sensors, drv} = '0;
		repeat (2) @(posedge clk_sys);
		check({remote_status_bits, rin_take_q, cmd_done_q, nv_save_q}, 19'h0);
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		t_default();
		t_tick();
		t_save();
		t_group();
		t_select();
		t_revert();
		end_of_test();
	end
endmodule : nsgs_top_bench
